/* File: pkg/remote_regs_pkg.sv */
package remote_regs_pkg;

   // Register byte addresses on the serial-port access path
   localparam logic [15:0] REMOTE_CHANNEL_SETUP_ADDR = 16'he708;
   localparam logic [15:0] SERIAL_PORT_LOCK_ADDR     = 16'hea00;

   // Field positions, remote-channel register
   localparam int PHASE_A_SEL_BIT   = 0;
   localparam int PHASE_B_SEL_BIT   = 1;
   localparam int PHASE_C_SEL_BIT   = 2;
   localparam int NEUTRAL_SEL_BIT   = 3;
   localparam int CLOCK_OUT_DIS_BIT = 6;
   localparam int SOFT_RESET_BIT    = 7;
   localparam logic [7:0] REMOTE_CHANNEL_WMASK = 8'h4F;

   // Field position, port-lock register
   localparam int PORT_LOCK_BIT = 0;

   // Values after reset
   localparam logic [7:0] REMOTE_CHANNEL_RESET = 8'h0F;
   localparam logic [7:0] SERIAL_PORT_LOCK_RESET = 8'h00;

   // Slave-select toggles that switch the device to its SPI port
   localparam logic [1:0] SPI_SELECT_TOGGLES = 2'h3;

   // Remote soft-reset pulse length, least time
   localparam int SOFT_RESET_PULSE_NS = 1000;
   localparam int CLK_SYS_PERIOD_NS   = 25;
   localparam int SOFT_RESET_CYCLES   =
      (SOFT_RESET_PULSE_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;

   // Remote clock output: half period in clk_sys cycles
   localparam int CLOCK_OUT_HALF_CYCLES = 5;

endpackage

/* File: pkg/port_select_if.sv */
`timescale 1ns/10ps
interface port_select_if;
   logic lock_write;     // Pulse: a write reached the port-lock register
   logic lock_value;     // Data bit written to the port-lock field
   logic spi_active;     // SPI is the chosen serial port
   logic locked;         // Serial-port choice is locked

   modport regs (output lock_write, output lock_value, input spi_active, input locked);
   modport selector (input lock_write, input lock_value, output spi_active, output locked);
endinterface

/* File: rtl/serial_port_selector.sv */
`timescale 1ns/10ps
module serial_port_selector (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Slave-select pin, asynchronous
   input  wire logic select_or_stream_active_pin,
   // Lock handshake with the register bank
   port_select_if.selector sel
);

   typedef struct packed {
      logic       ss_meta;
      logic       ss_sync;
      logic       ss_prev;
      logic [1:0] toggles;
      logic       spi_active;
      logic       locked;
   } sel_state_t;

   sel_state_t state;
   sel_state_t next_state;

   // Count low pulses on the pin; lock freezes the choice until reset
   always_comb begin
      next_state = state;
      next_state.ss_meta = select_or_stream_active_pin;
      next_state.ss_sync = state.ss_meta;
      next_state.ss_prev = state.ss_sync;
      if (!state.locked && !state.spi_active && state.ss_sync && !state.ss_prev) begin
         next_state.toggles = state.toggles + 2'h1;
         if (state.toggles + 2'h1 == remote_regs_pkg::SPI_SELECT_TOGGLES) begin
            next_state.spi_active = 1'b1;
         end
      end
      // In SPI any write locks; in I2C only a written 1 does
      if (sel.lock_write && (state.spi_active || sel.lock_value)) begin
         next_state.locked = 1'b1;
      end
      // Nothing but reset clears the lock or the chosen port
      if (state.locked) begin
         next_state.spi_active = state.spi_active;
         next_state.toggles    = state.toggles;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= '{ss_meta: 1'b1, ss_sync: 1'b1, ss_prev: 1'b1, toggles: 2'h0,
                    spi_active: 1'b0, locked: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign sel.spi_active = state.spi_active;
   assign sel.locked     = state.locked;

endmodule // serial_port_selector

/* File: rtl/remote_channel_and_port_lock_regs.sv */
`timescale 1ns/10ps
module remote_channel_and_port_lock_regs #(
   parameter int CLOCK_HALF = remote_regs_pkg::CLOCK_OUT_HALF_CYCLES,
   parameter int SR_CYCLES  = remote_regs_pkg::SOFT_RESET_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Register access from the serial-port engine
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rd_valid,
   // Serial-port choice
   input  wire logic        select_or_stream_active_pin,
   output logic             spi_port_active,
   output logic             port_choice_locked,
   // Remote converter controls
   output logic             phase_a_second_channel_select,
   output logic             phase_b_second_channel_select,
   output logic             phase_c_second_channel_select,
   output logic             neutral_second_channel_select,
   output logic             remote_clock_output_pin,
   output logic             remote_converter_soft_reset
);

   // Counter widths sized so the loaded value always fits
   localparam int SR_W  = $clog2(SR_CYCLES + 1);
   localparam int DIV_W = $clog2(CLOCK_HALF + 1);
   localparam logic [SR_W-1:0]  SR_LOAD  = SR_W'(SR_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLOCK_HALF - 1);

   typedef struct packed {
      logic [7:0]       chan;
      logic [7:0]       rdata;
      logic             rd_valid;
      logic [SR_W-1:0]  sr_count;
      logic [DIV_W-1:0] div_count;
      logic             clk_out;
   } regs_state_t;

   // State after reset: selects on the external inputs, remote clock
   // enabled and starting high, no pulse pending, no read answer
   localparam regs_state_t RESET_STATE = '{
      chan:      remote_regs_pkg::REMOTE_CHANNEL_RESET,
      rdata:     8'h00,
      rd_valid:  1'b0,
      sr_count:  '0,
      div_count: '0,
      clk_out:   1'b1
   };

   regs_state_t state;
   regs_state_t next_state;

   // Address decode
   logic       hit_chan;
   logic       hit_lock;
   // Qualified accesses
   logic       wr_chan;
   logic       wr_lock;
   logic       rd_chan;
   logic       rd_lock;
   // Remote-side helpers
   logic       soft_start;
   logic       sr_busy;
   logic       clock_stopped;
   logic       div_wrap;
   // Register images
   logic [7:0] chan_written;
   logic [7:0] chan_image;
   logic [7:0] lock_image;
   logic [7:0] read_word;

   port_select_if sel ();

   // Pin watch and lock keeping
   serial_port_selector u_selector (
      .clk_sys                     (clk_sys),
      .rst                         (rst),
      .select_or_stream_active_pin (select_or_stream_active_pin),
      .sel                         (sel.selector)
   );

   // Address decode
   assign hit_chan = (reg_addr == remote_regs_pkg::REMOTE_CHANNEL_SETUP_ADDR);
   assign hit_lock = (reg_addr == remote_regs_pkg::SERIAL_PORT_LOCK_ADDR);

   // Strobes qualified by address; unmapped addresses fall through
   assign wr_chan = reg_wr_en && hit_chan;
   assign wr_lock = reg_wr_en && hit_lock;
   assign rd_chan = reg_rd_en && hit_chan;
   assign rd_lock = reg_rd_en && hit_lock;

   // Lock request; the selector decides by the active port
   assign sel.lock_write = wr_lock;
   assign sel.lock_value = reg_wdata[remote_regs_pkg::PORT_LOCK_BIT];

   // Reserved bits masked at the door, so they never hold a one
   assign chan_written = reg_wdata & remote_regs_pkg::REMOTE_CHANNEL_WMASK;

   // A written 1 in bit 7 starts the pulse; it is never stored as such
   assign soft_start = wr_chan && reg_wdata[remote_regs_pkg::SOFT_RESET_BIT];
   assign sr_busy    = (state.sr_count != '0);

   // Divider status for the remote clock
   assign clock_stopped = state.chan[remote_regs_pkg::CLOCK_OUT_DIS_BIT];
   assign div_wrap      = (state.div_count == DIV_LAST);

   // Setup read image: stored fields plus the live pulse status
   always_comb begin
      chan_image = state.chan;
      chan_image[remote_regs_pkg::SOFT_RESET_BIT] = sr_busy;
   end

   // Lock read image: only the lock state, reserved bits zero
   always_comb begin
      lock_image = 8'h00;
      lock_image[remote_regs_pkg::PORT_LOCK_BIT] = sel.locked;
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      read_word = 8'h00;
      if (rd_chan) begin
         read_word = chan_image;
      end else if (rd_lock) begin
         read_word = lock_image;
      end
   end

   // Next-state logic for registers, soft-reset timer and clock output
   always_comb begin
      next_state = state;

      // Read answer stands for the one cycle after the request
      next_state.rd_valid = reg_rd_en;
      next_state.rdata    = read_word;

      // Writable fields only
      if (wr_chan) begin
         next_state.chan = chan_written;
      end

      // Pulse self-clears; a new start during a pulse restarts the full
      // length, so the remotes always see at least the documented width
      if (soft_start) begin
         next_state.sr_count = SR_LOAD;
      end else if (sr_busy) begin
         next_state.sr_count = state.sr_count - SR_W'(1);
      end

      // Clock output: divider runs only while enabled, else held high
      if (clock_stopped) begin
         next_state.div_count = '0;
         next_state.clk_out   = 1'b1;
      end else if (div_wrap) begin
         next_state.div_count = '0;
         next_state.clk_out   = ~state.clk_out;
      end else begin
         next_state.div_count = state.div_count + DIV_W'(1);
      end
   end

   // Select bits reset to external input; lock register resets clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= RESET_STATE;
      end else begin
         state <= next_state;
      end
   end

   // Channel steering: 0 measures temperature, 1 the external input
   assign phase_a_second_channel_select = state.chan[remote_regs_pkg::PHASE_A_SEL_BIT];
   assign phase_b_second_channel_select = state.chan[remote_regs_pkg::PHASE_B_SEL_BIT];
   assign phase_c_second_channel_select = state.chan[remote_regs_pkg::PHASE_C_SEL_BIT];
   assign neutral_second_channel_select = state.chan[remote_regs_pkg::NEUTRAL_SEL_BIT];

   // Remote clock straight from a flip-flop; soft reset decoded from the nonzero pulse counter
   assign remote_clock_output_pin     = state.clk_out;
   assign remote_converter_soft_reset = (state.sr_count != '0);

   // Host answers and port status
   assign reg_rdata          = state.rdata;
   assign reg_rd_valid       = state.rd_valid;
   assign spi_port_active    = sel.spi_active;
   assign port_choice_locked = sel.locked;

endmodule // remote_channel_and_port_lock_regs

/* File: sim/remote_regs_assertions.sv */
`timescale 1ns/10ps
module remote_regs_assertions #(parameter int SR_CYCLES = 4) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // Register writes
   input wire logic        reg_wr_en,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   // Port choice
   input wire logic        spi_port_active,
   input wire logic        port_choice_locked,
   // Remote controls
   input wire logic        phase_a_second_channel_select,
   input wire logic        remote_clock_output_pin,
   input wire logic        remote_converter_soft_reset
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [7:0] sr_cnt;
   logic       wcfg, wlock;
   // Decoded writes
   assign wcfg = reg_wr_en && reg_addr == 16'he708;
   assign wlock = reg_wr_en && reg_addr == 16'hea00;
   // Pulse length counter, 8 bits, so the check holds for SR_CYCLES up to 255
   always_ff @(posedge clk_sys) begin
      if (rst || !remote_converter_soft_reset) sr_cnt <= 8'h00;
      else sr_cnt <= sr_cnt + 8'h01;
   end
   // Register bank, remote controls and port lock
   a_sel_a_write: assert property (wcfg |=>
      phase_a_second_channel_select == $past(reg_wdata[0])) else $error("phase A select");
   a_sel_a_hold: assert property (!wcfg |=> $stable(phase_a_second_channel_select))
      else $error("phase A select moved");
   a_clock_held_high: assert property (wcfg && reg_wdata[6] |->
      ##2 remote_clock_output_pin [*6]) else $error("remote clock not held high");
   a_soft_start: assert property (wcfg && reg_wdata[7] |=> remote_converter_soft_reset)
      else $error("soft reset not started");
   a_soft_length: assert property ($fell(remote_converter_soft_reset) |->
      sr_cnt == SR_CYCLES) else $error("soft reset pulse length");
   a_lock_by_one: assert property (wlock && reg_wdata[0] |=> port_choice_locked)
      else $error("lock by one missed");
   a_lock_in_spi: assert property (wlock && spi_port_active |=> port_choice_locked)
      else $error("lock in spi missed");
   a_lock_sticky: assert property (port_choice_locked |=>
      port_choice_locked && $stable(spi_port_active)) else $error("lock or port changed");
   a_spi_sticky: assert property (spi_port_active |=> spi_port_active)
      else $error("spi dropped");
   c_spi_lock: cover property (spi_port_active && wlock);
   c_i2c_lock: cover property (!spi_port_active && wlock && reg_wdata[0]);
   c_soft_done: cover property ($fell(remote_converter_soft_reset));
endmodule // remote_regs_assertions
bind remote_channel_and_port_lock_regs remote_regs_assertions #(.SR_CYCLES(SR_CYCLES)) chk (
   .clk_sys, .rst, .reg_wr_en, .spi_port_active, .port_choice_locked, .reg_addr, .reg_wdata,
   .phase_a_second_channel_select, .remote_clock_output_pin, .remote_converter_soft_reset);

/* File: sim/host_model.sv */
`timescale 1ns/10ps
module host_model (
   // Clock
   input  wire logic        clk_sys,
   // Register access
   output logic             reg_wr_en,
   output logic             reg_rd_en,
   output logic      [15:0] reg_addr,
   output logic      [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        reg_rd_valid,
   // Slave-select pin, idle high
   output logic             select_or_stream_active_pin
);
   // Idle bus; released lines show the inverse of the last value
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      select_or_stream_active_pin = 1'b1;
   end
   // One-edge write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // Read; data only counts when the valid pulse stands
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hxx;
   endtask
   // One low pulse on the select pin, long enough for the synchroniser
   task automatic toggle();
      @(posedge clk_sys);
      select_or_stream_active_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      select_or_stream_active_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
endmodule // host_model

/* File: sim/remote_channel_and_port_lock_regs_tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module remote_channel_and_port_lock_regs_tb_top;
   localparam int SR = 4;
   localparam int HALF = 2;
   logic clk_sys, rst, reg_wr_en, reg_rd_en, reg_rd_valid, select_or_stream_active_pin;
   logic spi_port_active, port_choice_locked, remote_clock_output_pin;
   logic remote_converter_soft_reset, phase_a_second_channel_select;
   logic phase_b_second_channel_select, phase_c_second_channel_select;
   logic neutral_second_channel_select;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [3:0] sels;
   int fails, compares, k;
   assign sels = {neutral_second_channel_select, phase_c_second_channel_select,
      phase_b_second_channel_select, phase_a_second_channel_select};
   remote_channel_and_port_lock_regs #(.CLOCK_HALF(HALF), .SR_CYCLES(SR)) dut (
      .clk_sys, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
      .select_or_stream_active_pin, .spi_port_active, .port_choice_locked,
      .phase_a_second_channel_select, .phase_b_second_channel_select,
      .phase_c_second_channel_select, .neutral_second_channel_select,
      .remote_clock_output_pin, .remote_converter_soft_reset);
   host_model host (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rd_valid, .select_or_stream_active_pin);
   // Clock, 25 ns period
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic do_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   task automatic t_reset();
      @(posedge clk_sys);
      #1;
      `CHK("selects", 4'hf, sels)
      `CHK("soft reset", 1'b0, remote_converter_soft_reset)
      host.rd(16'he708, d);
      `CHK("setup reg", 8'h0f, d)
      host.rd(16'hea00, d);
      `CHK("lock reg", 8'h00, d)
      host.rd(16'h1234, d);
      `CHK("unmapped", 8'h00, d)
      $display("test reset done");
   endtask
   // Clear each select in turn, reserved bits written high
   task automatic t_selects();
      for (int i = 0; i < 4; i++) begin
         host.wr(16'he708, 8'h3f ^ (8'h01 << i));
         #1;
         `CHK("select", 4'hf ^ (4'h1 << i), sels)
         host.rd(16'he708, d);
         `CHK("setup readback", 8'h0f ^ (8'h01 << i), d)
      end
      $display("test selects done");
   endtask
   task automatic t_clock_out();
      host.wr(16'he708, 8'h4f);
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 4 * HALF; i++) begin
         @(posedge clk_sys);
         #1;
         `CHK("clock held", 1'b1, remote_clock_output_pin)
      end
      host.wr(16'he708, 8'h0f);
      k = 0;
      repeat (4 * HALF + 4) begin
         @(posedge clk_sys);
         #1;
         k += (remote_clock_output_pin === 1'b0);
      end
      `CHK("clock low samples", 2 * HALF + 2, k)
      $display("test clock output done");
   endtask
   task automatic t_soft();
      host.wr(16'he708, 8'h8f);
      #1;
      k = (remote_converter_soft_reset === 1'b1);
      repeat (SR + 4) begin
         @(posedge clk_sys);
         #1;
         k += (remote_converter_soft_reset === 1'b1);
      end
      `CHK("soft pulse", SR, k)
      host.rd(16'he708, d);
      `CHK("soft bit clear", 8'h0f, d)
      $display("test soft reset done");
   endtask
   task automatic t_i2c();
      host.wr(16'hea00, 8'hfe);
      #1;
      `CHK("no lock on zero", 1'b0, port_choice_locked)
      host.wr(16'hea00, 8'hff);
      host.rd(16'hea00, d);
      `CHK("lock reg", 8'h01, d)
      repeat (3) host.toggle();
      host.wr(16'hea00, 8'h00);
      host.rd(16'hea00, d);
      `CHK("lock kept", 8'h01, d)
      `CHK("toggles ignored", 1'b0, spi_port_active)
      $display("test i2c lock done");
   endtask
   task automatic t_spi();
      do_reset();
      repeat (2) host.toggle();
      #1;
      `CHK("two toggles", 1'b0, spi_port_active)
      host.toggle();
      #1;
      `CHK("spi on", 1'b1, spi_port_active)
      host.wr(16'hea00, 8'h00);
      host.rd(16'hea00, d);
      `CHK("spi lock", 8'h01, d)
      $display("test spi lock done");
   endtask
   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      fails = 0;
      compares = 0;
      do_reset();
      t_reset();
      t_selects();
      t_clock_out();
      t_soft();
      t_i2c();
      t_spi();
      end_of_test();
   end
   // Hang guard, well beyond the roughly 145 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      end_of_test();
   end
endmodule // remote_channel_and_port_lock_regs_tb_top
